// *** scx_target.sv ***
// Target end: drives phase lines and REQ, moves bytes async or sync.
// Assumes initiator end keeps its side of the handshake; bus inputs synchronous
// to clk, re-registered once here before use.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Phase coded on msg, cd, io
// - Initiator asks message out with atn
// - Release phase lines and bsy to free
// - One byte plus parity per handshake
// - Bsy true, sel false during transfer
// - Phase stable settle before first req
// - Phase valid only at first req
// - Io true means target to initiator
// - Inbound: data, skew wait, req, hold
// - Inbound async interlock of req, ack
// - Outbound: initiator data, skew, ack
// - Outbound: sample on ack, req low
// - Sync only in data phases
// - Hold req when offset reached
// - Sync done when counts equal
// - Req assertion and spacing periods
// - Initiator one ack per req
// - Sync inbound data hold times
// - Sync outbound target samples at ack
// - Initiator tolerates req at boundary
module scx_target
    import scx_pkg::*;
#(
    parameter int OFS_W = SCX_OFS_W
) (
    input  wire logic                 clk,          // Clock 100 MHz
    input  wire logic                 sys_rst,      // Async reset, high
    scx_bus_if.target                 bus,          // Bus side
    input  wire logic                 connect,      // Hold bsy while high
    input  wire logic                 start,        // Pulse: begin a phase
    input  wire scx_phase_type        phase,        // Phase for start
    input  wire logic [15:0]          xfer_len,     // Bytes in phase, >=1
    input  wire logic                 sync_en,      // Sync agreement active
    input  wire logic [OFS_W-1:0]     sync_offset,  // Agreed offset, >=1
    input  wire logic [SCX_CNT_W-1:0] settle_cyc,   // Bus settle count
    input  wire logic [SCX_CNT_W-1:0] skew_cyc,     // Deskew+skew count
    input  wire logic [SCX_CNT_W-1:0] hold_cyc,     // Deskew+skew+hold count
    input  wire logic [SCX_CNT_W-1:0] assert_cyc,   // Assertion period
    input  wire logic [SCX_CNT_W-1:0] negate_cyc,   // Negation period
    input  wire logic [SCX_CNT_W-1:0] period_cyc,   // Transfer period
    input  wire logic                 tx_valid,     // Inbound byte ready
    output logic                      tx_ready,     // Inbound byte taken
    input  wire logic [7:0]           tx_data,      // Inbound byte
    output logic                      rx_valid,     // Pulse: outbound byte
    output logic [8:0]                rx_data,      // Byte and parity
    output logic                      atn_seen,     // Attention level
    output logic                      busy,         // Phase in progress
    output logic                      done,         // Pulse: phase ended
    output logic                      sync_err      // Sync ack with no req outstanding
);
    if (OFS_W < 1 || OFS_W > 16) begin : g_ofs_chk
        $error("OFS_W out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE, ST_SKEW, ST_REQ, ST_WACK_LO, ST_SYNC_GAP, ST_DRAIN
    } scx_tstate_type;

    typedef struct packed {
        scx_tstate_type     st;
        logic [2:0]         ph;
        logic               conn;
        logic               req;
        logic               db_oe;
        logic [8:0]         db;
        logic [SCX_CNT_W-1:0] cnt;
        logic [SCX_CNT_W-1:0] hcnt;
        logic [SCX_CNT_W-1:0] pcnt;
        logic [15:0]        left;
        logic [OFS_W:0]     outst;
        logic               sync;
        logic               ack_s;
        logic               ack_p;
        logic               atn_s;
        logic [8:0]         db_s;
        logic               rxv;
        logic [8:0]         rxd;
        logic               done;
        logic               err;
    } scx_tregs_type;

    scx_tregs_type r_q, r_d;
    logic ack_rise, inbound;

    assign ack_rise = r_q.ack_s && !r_q.ack_p;
    assign inbound  = r_q.ph[0];

    always_comb begin
        r_d       = r_q;
        r_d.ack_s = bus.ack;
        r_d.ack_p = r_q.ack_s;
        r_d.atn_s = bus.atn;
        r_d.db_s  = bus.db;
        r_d.conn  = connect;
        r_d.rxv   = 1'b0;
        r_d.done  = 1'b0;
        tx_ready  = 1'b0;
        if (r_q.hcnt != '0) r_d.hcnt = r_q.hcnt - 1'b1;
        if (r_q.pcnt != '0) r_d.pcnt = r_q.pcnt - 1'b1;
        // Sync pacing: one outstanding req retired per ack leading edge
        if (r_q.sync && ack_rise) begin
            r_d.outst = r_q.outst - 1'b1;
            if (!inbound) begin
                r_d.rxv = 1'b1;
                r_d.rxd = r_q.db_s;
            end
        end
        if (r_q.sync && r_q.hcnt == SCX_CNT_W'(1) && r_q.req == 1'b0 && inbound)
            r_d.db_oe = 1'b0;
        unique case (r_q.st)
            ST_IDLE: begin
                if (start && connect) begin
                    r_d.ph   = phase;
                    r_d.left = xfer_len;
                    r_d.sync = sync_en && !phase[1] && !phase[2];
                    r_d.outst = '0;
                    r_d.err  = 1'b0;
                    r_d.cnt  = settle_cyc;
                    r_d.st   = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (r_q.cnt != '0) r_d.cnt = r_q.cnt - 1'b1;
                else if (!r_q.ack_s) begin
                    r_d.st = ST_SKEW;
                    r_d.cnt = skew_cyc;
                end
            end
            ST_SKEW: begin
                // Load inbound byte, wait skew, gate on pacing
                if (inbound && !r_q.db_oe) begin
                    if (tx_valid) begin
                        tx_ready = 1'b1;
                        r_d.db   = {~^tx_data, tx_data};
                        r_d.db_oe = 1'b1;
                        r_d.cnt  = skew_cyc;
                    end
                end else if (r_q.cnt != '0) begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end else if (!r_q.sync ||
                             (r_q.outst < {1'b0, sync_offset} && r_q.pcnt == '0)) begin
                    r_d.req  = 1'b1;
                    r_d.st   = ST_REQ;
                    r_d.cnt  = assert_cyc;
                    r_d.left = r_q.left - 1'b1;
                    if (r_q.sync) begin
                        // Builds on any retire taken in this same cycle
                        r_d.outst = r_d.outst + 1'b1;
                        r_d.hcnt = hold_cyc;
                        r_d.pcnt = period_cyc;
                    end
                end
            end
            ST_REQ: begin
                if (r_q.sync) begin
                    if (r_q.cnt > SCX_CNT_W'(1)) r_d.cnt = r_q.cnt - 1'b1;
                    else begin
                        r_d.req = 1'b0;
                        if (r_q.pcnt < negate_cyc) r_d.pcnt = negate_cyc;
                        r_d.st  = (r_q.left == '0) ? ST_DRAIN : ST_SYNC_GAP;
                    end
                end else if (r_q.ack_s) begin
                    r_d.req = 1'b0;
                    if (inbound) r_d.db_oe = 1'b0;
                    else begin
                        r_d.rxv = 1'b1;
                        r_d.rxd = r_q.db_s;
                    end
                    r_d.st = ST_WACK_LO;
                end
            end
            ST_WACK_LO: begin
                if (!r_q.ack_s) begin
                    r_d.cnt = skew_cyc;
                    if (r_q.left == '0) begin
                        r_d.st   = ST_IDLE;
                        r_d.done = 1'b1;
                    end else r_d.st = ST_SKEW;
                end
            end
            ST_SYNC_GAP: begin
                if (!inbound || r_q.hcnt == '0) begin
                    r_d.db_oe = r_q.db_oe && !inbound;
                    r_d.cnt   = '0;
                    r_d.st    = ST_SKEW;
                end
            end
            ST_DRAIN: begin
                // Wait until every req is matched by an ack and ack is low
                if (r_q.outst == '0 && !r_q.ack_s && r_q.hcnt == '0) begin
                    r_d.db_oe = 1'b0;
                    r_d.st    = ST_IDLE;
                    r_d.done  = 1'b1;
                end
            end
            default: r_d.st = ST_IDLE;
        endcase
        if (r_q.sync && ack_rise && r_q.outst == '0) r_d.err = 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_q <= '{st: ST_IDLE, ph: 3'h0, db: SCX_DATA_RST, rxd: SCX_DATA_RST,
                     cnt: '0, hcnt: '0, pcnt: '0, left: '0, outst: '0, default: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // Bus drive: lines released (enable high) when idle and free
    // ------------------------------------------------------------
    assign bus.bsy_oe_n    = !r_q.conn;
    assign bus.sel_oe_n    = 1'b1;
    assign bus.msg_oe_n    = !(r_q.conn && r_q.ph[2]);
    assign bus.cd_oe_n     = !(r_q.conn && r_q.ph[1]);
    assign bus.io_oe_n     = !(r_q.conn && r_q.ph[0]);
    assign bus.req_oe_n    = !r_q.req;
    assign bus.tgt_db_o    = r_q.db;
    assign bus.tgt_db_oe_n = !r_q.db_oe;
    assign rx_valid = r_q.rxv;
    assign rx_data  = r_q.rxd;
    assign atn_seen = r_q.atn_s;
    assign busy     = (r_q.st != ST_IDLE);
    assign done     = r_q.done;
    assign sync_err = r_q.err;
endmodule : scx_target
`default_nettype wire

// *** scx_pkg.sv ***
// Shared constants and types for the information transfer handshake ends.
// Assumes one 100 MHz clock and asynchronous active-high reset in both ends.
package scx_pkg;
    // ------------------------------------------------------------
    // Phase encoding {msg, cd, io}
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCX_PH_DATA_OUT = 3'h0,
        SCX_PH_DATA_IN  = 3'h1,
        SCX_PH_COMMAND  = 3'h2,
        SCX_PH_STATUS   = 3'h3,
        SCX_PH_MSG_OUT  = 3'h6,
        SCX_PH_MSG_IN   = 3'h7
    } scx_phase_type;

    localparam int SCX_CNT_W       = 16;
    localparam int SCX_OFS_W       = 8;
    localparam int SCX_CLK_MHZ     = 100;
    // Default bus timings in ns
    localparam int SCX_SETTLE_NS   = 400;
    localparam int SCX_DESKEW_NS   = 45;
    localparam int SCX_SKEW_NS     = 10;
    localparam int SCX_HOLD_NS     = 45;
    localparam int SCX_ASSERT_NS   = 90;
    localparam int SCX_NEGATE_NS   = 90;
    localparam int SCX_PERIOD_NS   = 200;
    // Default counts in cycles, least times rounded up
    localparam logic [SCX_CNT_W-1:0] SCX_SETTLE_CYC =
        SCX_CNT_W'((SCX_SETTLE_NS * SCX_CLK_MHZ + 999) / 1000);
    localparam logic [SCX_CNT_W-1:0] SCX_SKEW_CYC =
        SCX_CNT_W'(((SCX_DESKEW_NS + SCX_SKEW_NS) * SCX_CLK_MHZ + 999) / 1000);
    localparam logic [SCX_CNT_W-1:0] SCX_HOLD_CYC =
        SCX_CNT_W'(((SCX_DESKEW_NS + SCX_SKEW_NS + SCX_HOLD_NS) * SCX_CLK_MHZ + 999)
        / 1000);
    localparam logic [SCX_CNT_W-1:0] SCX_ASSERT_CYC =
        SCX_CNT_W'((SCX_ASSERT_NS * SCX_CLK_MHZ + 999) / 1000);
    localparam logic [SCX_CNT_W-1:0] SCX_NEGATE_CYC =
        SCX_CNT_W'((SCX_NEGATE_NS * SCX_CLK_MHZ + 999) / 1000);
    localparam logic [SCX_CNT_W-1:0] SCX_PERIOD_CYC =
        SCX_CNT_W'((SCX_PERIOD_NS * SCX_CLK_MHZ + 999) / 1000);
    localparam logic [8:0] SCX_DATA_RST = 9'h000;
endpackage : scx_pkg

// *** scx_bus_if.sv ***
// Bus wires between target and initiator of one information transfer link.
// Assumes both ends run on the same clk; open-drain wires resolved here.
`timescale 1ns/10ps
`default_nettype none
interface scx_bus_if;
    logic       msg_oe_n;   // Target phase lines, enable low = driven true
    logic       cd_oe_n;
    logic       io_oe_n;
    logic       bsy_oe_n;
    logic       sel_oe_n;
    logic       req_oe_n;
    logic       ack_oe_n;   // Initiator
    logic       atn_oe_n;   // Initiator
    logic [8:0] tgt_db_o;   // Target data with parity in bit 8
    logic       tgt_db_oe_n;
    logic [8:0] ini_db_o;
    logic       ini_db_oe_n;
    logic       msg, cd, io, bsy, sel, req, ack, atn;
    logic [8:0] db;

    // ------------------------------------------------------------
    // Wired bus levels (true = asserted)
    // ------------------------------------------------------------
    assign msg = !msg_oe_n;
    assign cd  = !cd_oe_n;
    assign io  = !io_oe_n;
    assign bsy = !bsy_oe_n;
    assign sel = !sel_oe_n;
    assign req = !req_oe_n;
    assign ack = !ack_oe_n;
    assign atn = !atn_oe_n;
    assign db  = (!tgt_db_oe_n ? tgt_db_o : 9'h000) | (!ini_db_oe_n ? ini_db_o : 9'h000);

    modport target (output msg_oe_n, cd_oe_n, io_oe_n, bsy_oe_n, sel_oe_n, req_oe_n,
                    tgt_db_o, tgt_db_oe_n, input ack, atn, db);
    modport initiator (output ack_oe_n, atn_oe_n, ini_db_o, ini_db_oe_n,
                       input msg, cd, io, req, db);
endinterface : scx_bus_if
`default_nettype wire

// *** scx_initiator.sv ***
// Initiator end: answers each REQ with ACK, supplies or captures bytes.
// Assumes the target end keeps its side; bus inputs registered once here.
`timescale 1ns/10ps
`default_nettype none
module scx_initiator
    import scx_pkg::*;
(
    input  wire logic                 clk,          // Clock 100 MHz
    input  wire logic                 sys_rst,      // Async reset, high
    scx_bus_if.initiator              bus,          // Bus side
    input  wire logic                 attn,         // Request message out
    input  wire logic                 sync_en,      // Sync agreement active
    input  wire logic [SCX_CNT_W-1:0] skew_cyc,     // Deskew+skew count
    input  wire logic [SCX_CNT_W-1:0] hold_cyc,     // Deskew+skew+hold count
    input  wire logic [SCX_CNT_W-1:0] assert_cyc,   // Assertion period
    input  wire logic [SCX_CNT_W-1:0] negate_cyc,   // Negation period
    input  wire logic [SCX_CNT_W-1:0] period_cyc,   // Transfer period
    input  wire logic                 tx_valid,     // Outbound byte ready
    output logic                      tx_ready,     // Outbound byte taken
    input  wire logic [7:0]           tx_data,      // Outbound byte
    output logic                      rx_valid,     // Pulse: inbound byte
    output logic [8:0]                rx_data,      // Byte and parity
    output logic [2:0]                cur_phase     // Phase at last req
);
    typedef enum logic [1:0] {ST_IDLE, ST_SKEW, ST_ACK, ST_WREQ_LO} scx_istate_type;

    typedef struct packed {
        scx_istate_type     st;
        logic               req_s, req_p;
        logic [2:0]         ph_s;
        logic [8:0]         db_s;
        logic               sync;
        logic [15:0]        pend;
        logic               ack;
        logic               db_oe;
        logic [8:0]         db;
        logic [SCX_CNT_W-1:0] cnt, hcnt, pcnt;
        logic               rxv;
        logic [8:0]         rxd;
        logic [2:0]         ph;
    } scx_iregs_type;

    scx_iregs_type r_q, r_d;
    logic req_rise, inbound;

    assign req_rise = r_q.req_s && !r_q.req_p;
    assign inbound  = r_q.ph_s[0];

    always_comb begin
        r_d       = r_q;
        r_d.req_s = bus.req;
        r_d.req_p = r_q.req_s;
        r_d.ph_s  = {bus.msg, bus.cd, bus.io};
        r_d.db_s  = bus.db;
        r_d.rxv   = 1'b0;
        tx_ready  = 1'b0;
        if (r_q.hcnt != '0) r_d.hcnt = r_q.hcnt - 1'b1;
        if (r_q.pcnt != '0) r_d.pcnt = r_q.pcnt - 1'b1;
        if (r_q.hcnt == SCX_CNT_W'(1) && !r_q.ack) r_d.db_oe = 1'b0;
        // Phase is taken as valid only when req rises
        if (req_rise) begin
            r_d.ph   = r_q.ph_s;
            r_d.sync = sync_en && !r_q.ph_s[1] && !r_q.ph_s[2];
            if (sync_en && !r_q.ph_s[1] && !r_q.ph_s[2]) begin
                r_d.pend = r_q.pend + 1'b1;
                if (inbound) begin
                    r_d.rxv = 1'b1;
                    r_d.rxd = r_q.db_s;
                end
            end
        end
        unique case (r_q.st)
            ST_IDLE: begin
                if ((r_d.sync && r_d.pend != '0 && r_q.pcnt == '0) ||
                    (!r_q.sync && r_q.req_s && !req_rise)) begin
                    if (!inbound) begin
                        if (tx_valid && r_q.hcnt == '0) begin
                            tx_ready  = 1'b1;
                            r_d.db    = {~^tx_data, tx_data};
                            r_d.db_oe = 1'b1;
                            r_d.cnt   = skew_cyc;
                            r_d.st    = ST_SKEW;
                        end
                    end else begin
                        if (!r_d.sync) begin
                            r_d.rxv = 1'b1;
                            r_d.rxd = r_q.db_s;
                        end
                        r_d.cnt = '0;
                        r_d.st  = ST_SKEW;
                    end
                end
            end
            ST_SKEW: begin
                if (r_q.cnt != '0) r_d.cnt = r_q.cnt - 1'b1;
                else begin
                    r_d.ack = 1'b1;
                    r_d.cnt = assert_cyc;
                    if (r_q.sync) begin
                        r_d.pend = r_d.pend - 1'b1;
                        r_d.pcnt = period_cyc;
                        if (!inbound) r_d.hcnt = hold_cyc;
                    end
                    r_d.st  = r_q.sync ? ST_ACK : ST_WREQ_LO;
                end
            end
            ST_ACK: begin
                if (r_q.cnt > SCX_CNT_W'(1)) r_d.cnt = r_q.cnt - 1'b1;
                else begin
                    r_d.ack = 1'b0;
                    if (r_q.pcnt < negate_cyc) r_d.pcnt = negate_cyc;
                    r_d.st  = ST_IDLE;
                end
            end
            ST_WREQ_LO: begin
                if (!r_q.req_s) begin
                    r_d.ack   = 1'b0;
                    r_d.db_oe = 1'b0;
                    r_d.st    = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_q <= '{st: ST_IDLE, ph_s: 3'h0, db_s: SCX_DATA_RST, db: SCX_DATA_RST,
                     rxd: SCX_DATA_RST, ph: 3'h0, pend: '0, cnt: '0, hcnt: '0,
                     pcnt: '0, default: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign bus.ack_oe_n    = !r_q.ack;
    assign bus.atn_oe_n    = !attn;
    assign bus.ini_db_o    = r_q.db;
    assign bus.ini_db_oe_n = !r_q.db_oe;
    assign rx_valid  = r_q.rxv;
    assign rx_data   = r_q.rxd;
    assign cur_phase = r_q.ph;
endmodule : scx_initiator
`default_nettype wire

// *** scx_asserts.sv ***
// Concurrent checks on the bus wires joining the target and initiator ends.
// Assumes the bench places it beside the bus interface; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module scx_asserts
    import scx_pkg::*;
#(
    parameter int SETTLE = int'(SCX_SETTLE_CYC) // Settle count in use
) (
    input wire logic       clk,     // Clock
    input wire logic       sys_rst, // Async reset, high
    input wire logic       msg,     // Phase line
    input wire logic       cd,      // Phase line
    input wire logic       io,      // Phase line, direction
    input wire logic       bsy,     // Busy level
    input wire logic       sel,     // Select level
    input wire logic       req,     // Target request
    input wire logic       ack,     // Initiator acknowledge
    input wire logic [8:0] db       // Data with parity
);
    logic [2:0]  ph_q;
    logic [15:0] stab_q;
    logic [15:0] outst_q;
    logic        req_q;
    logic        ack_q;

    // ------------------------------------------------------------
    // Phase stability age and outstanding request count
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_q <= 3'h0;
            stab_q <= 16'h0000;
            outst_q <= 16'h0000;
            req_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            ph_q <= {msg, cd, io};
            stab_q <= ({msg, cd, io} != ph_q) ? 16'h0000 : stab_q + 16'(stab_q != 16'hffff);
            outst_q <= outst_q + 16'(req && !req_q) - 16'(ack && !ack_q);
            req_q <= req;
            ack_q <= ack;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_phase_code: assert property (req |-> !(msg && !cd))
        else $error("reserved phase code during request");
    a_bsy_held: assert property ((req || ack) |-> bsy)
        else $error("busy not held during handshake");
    a_sel_released: assert property (bsy |-> !sel)
        else $error("select true while connected");
    a_phase_stable: assert property (((req || ack) && $past(req || ack)) |-> $stable({msg, cd, io}))
        else $error("phase lines moved inside handshake");
    a_settle_first: assert property ($rose(req) |-> stab_q >= 16'(SETTLE))
        else $error("request before phase settled");
    a_parity_in: assert property ((req && io && !ack && $past(req)) |-> ^db)
        else $error("inbound byte parity not odd");
    a_data_in_stable: assert property ((req && io && !ack && $past(req && io && !ack)) |-> $stable(db))
        else $error("inbound data moved before acknowledge");
    a_req_drops: assert property ($rose(ack) |-> ##[0:16] !req)
        else $error("request not negated after acknowledge");
    a_ack_answers: assert property ($rose(req) |-> ##[1:60] ack)
        else $error("request not answered by acknowledge");
    a_no_stray_ack: assert property ($rose(ack) |-> outst_q != 16'h0000)
        else $error("acknowledge without outstanding request");
    a_free_release: assert property ($fell(bsy) |-> !msg && !cd && !io && !req && outst_q == 16'h0000)
        else $error("bus freed with lines held or counts unequal");
endmodule // scx_asserts
`default_nettype wire

// *** tb_scsi_info_transfer_handshake.sv ***
// Self-checking bench: target and initiator ends joined over one bus.
// Assumes package default timings; phases drawn at random plus corner cases.
`timescale 1ns/10ps
`default_nettype none
module tb_scsi_info_transfer_handshake;
    import scx_pkg::*;
    logic clk, sys_rst, connect, start, sync_en, attn, t_tv, i_tv;
    logic t_rdy, i_rdy, t_rxv, i_rxv, atn_seen, busy, done, sync_err;
    logic [7:0] ofs, t_txd, i_txd;
    logic [8:0] t_rxd, i_rxd;
    logic [2:0] cur_phase;
    logic [15:0] xfer_len, stl, skw, hld, asr, neg, per;
    scx_phase_type phase;
    scx_phase_type phs [6] = '{SCX_PH_DATA_OUT, SCX_PH_DATA_IN, SCX_PH_COMMAND,
                               SCX_PH_STATUS, SCX_PH_MSG_OUT, SCX_PH_MSG_IN};
    int fail_count, cmp_count, n_rx;
    logic [7:0] q[$];

    scx_bus_if bus ();
    scx_target scx_target_i (.clk(clk), .sys_rst(sys_rst), .bus(bus), .connect(connect),
        .start(start), .phase(phase), .xfer_len(xfer_len), .sync_en(sync_en),
        .sync_offset(ofs), .settle_cyc(stl), .skew_cyc(skw), .hold_cyc(hld),
        .assert_cyc(asr), .negate_cyc(neg), .period_cyc(per), .tx_valid(t_tv),
        .tx_ready(t_rdy), .tx_data(t_txd), .rx_valid(t_rxv), .rx_data(t_rxd),
        .atn_seen(atn_seen), .busy(busy), .done(done), .sync_err(sync_err));
    scx_initiator scx_initiator_i (.clk(clk), .sys_rst(sys_rst), .bus(bus), .attn(attn),
        .sync_en(sync_en), .skew_cyc(skw), .hold_cyc(hld), .assert_cyc(asr),
        .negate_cyc(neg), .period_cyc(per), .tx_valid(i_tv), .tx_ready(i_rdy),
        .tx_data(i_txd), .rx_valid(i_rxv), .rx_data(i_rxd), .cur_phase(cur_phase));
    scx_asserts #(.SETTLE(int'(SCX_SETTLE_CYC))) scx_asserts_i (.clk(clk), .sys_rst(sys_rst),
        .msg(bus.msg), .cd(bus.cd), .io(bus.io), .bsy(bus.bsy), .sel(bus.sel),
        .req(bus.req), .ack(bus.ack), .db(bus.db));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Byte with odd parity in bit 8
    function automatic logic [8:0] odd_par(input logic [7:0] b);
        logic p;
        p = 1'b1;
        for (int j = 0; j < 8; j++) p = p ^ b[j];
        return {p, b};
    endfunction

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bytes offered by either end are queued; the receiving end must match
    always @(posedge clk) begin
        if (t_tv && t_rdy) q.push_back(t_txd);
        if (i_tv && i_rdy) q.push_back(i_txd);
        if (t_rxv || i_rxv) begin
            n_rx++;
            chk("rx_side", 16'(t_rxv), 16'(!phase[0]));
            chk("rx_byte", 16'(t_rxv ? t_rxd : i_rxd),
                q.size() ? 16'(odd_par(q[0])) : 16'hffff);
            if (q.size()) void'(q.pop_front());
        end
        if (t_rdy) t_txd <= #1 8'($urandom);
        if (i_rdy) i_txd <= #1 8'($urandom);
    end

    task automatic run(input scx_phase_type ph, input int len, input logic sy, input int of);
        int k;
        @(posedge clk);
        #1 phase = ph;
        xfer_len = 16'(len);
        sync_en = sy;
        ofs = 8'(of);
        start = 1'b1;
        n_rx = 0;
        @(posedge clk);
        #1 start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 5000) begin
            chk("timeout", 16'h0001, 16'h0000);
            conclude();
        end
        repeat (2) @(posedge clk);
        #1 chk("byte_count", 16'(n_rx), 16'(len));
        chk("phase_seen", 16'(cur_phase), 16'(ph));
        chk("sync_err", 16'(sync_err), 16'h0000);
        chk("busy", 16'(busy), 16'h0000);
        $display("test phase %0d len %0d sync %0b offset %0d ended", ph, len, sy, of);
    endtask

    initial begin
        void'($urandom(97));
        {start, attn, sync_en, connect, t_tv, i_tv, n_rx} = '0;
        {sys_rst, fail_count, cmp_count} = '0;
        sys_rst = 1'b1;
        phase = SCX_PH_DATA_OUT;
        {xfer_len, ofs, t_txd, i_txd} = '0;
        {stl, skw, hld} = {SCX_SETTLE_CYC, SCX_SKEW_CYC, SCX_HOLD_CYC};
        {asr, neg, per} = {SCX_ASSERT_CYC, SCX_NEGATE_CYC, SCX_PERIOD_CYC};
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        {connect, t_tv, i_tv} = 3'h7;
        run(SCX_PH_DATA_IN, 1, 1'b0, 1);
        run(SCX_PH_DATA_OUT, 8, 1'b1, 1);
        run(SCX_PH_DATA_IN, 8, 1'b1, 1);
        run(SCX_PH_STATUS, 2, 1'b1, 3);
        foreach (phs[i]) run(phs[i], 3, 1'b0, 1);
        repeat (14) run(phs[$urandom % 6], 1 + $urandom % 6, 1'($urandom), 1 + $urandom % 3);
        attn = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("atn_seen", 16'(atn_seen), 16'h0001);
        attn = 1'b0;
        connect = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("bus_free", 16'({bus.bsy, bus.msg, bus.cd, bus.io}), 16'h0000);
        conclude();
    end
endmodule // tb_scsi_info_transfer_handshake
`default_nettype wire
